//--- core/rts_pkg.sv
// Purpose: Shared constants and types for the reset and start-up sequencer
// Assumes: 100 MHz system clock, synchronous active-high reset
// Notes:   Register indices are word indices; byte address is index times four
package rts_pkg;

    // System clock
    localparam int CLK_FREQ_MHZ  = 100;
    localparam int CLK_PERIOD_NS = 10;

    // Power-up delay on the RC time base
    localparam int POWERUP_DELAY_MS = 72;
    localparam int RC_TIMEBASE_KHZ  = 1000;
    localparam int POWERUP_RC_TICKS = POWERUP_DELAY_MS * RC_TIMEBASE_KHZ;
    localparam int PUD_CNT_W        = 24;

    // Oscillator start-up count on the oscillator input
    localparam int OSU_OSC_CYCLES = 1024;
    localparam int OSU_CNT_W      = 10;

    // Brown-out qualification time
    localparam int BROWNOUT_QUALIFY_US     = 100;
    localparam int BROWNOUT_QUALIFY_CYCLES = BROWNOUT_QUALIFY_US * CLK_FREQ_MHZ;
    localparam int BRO_CNT_W               = 14;

    // Master-clear glitch filter, least time rounds up
    localparam int CLR_FILTER_NS     = 200;
    localparam int CLR_FILTER_CYCLES = (CLR_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLR_CNT_W         = 5;

    // Register map (word indices)
    localparam logic [13:0] REG_STATUS_IDX = 14'h0001;
    localparam logic [13:0] REG_CONFIG_IDX = 14'h2007;

    // Configuration word: programmed bit reads 0, unprogrammed reads 1
    localparam int              CFG_W          = 14;
    localparam logic [13:0]     CFG_RESET      = 14'h3FFF;
    localparam int              CFG_OSC_LSB    = 0;
    localparam int              CFG_WDOG_EN_BIT = 2;
    localparam int              CFG_PUD_EN_N    = 3;
    localparam int              CFG_BRO_EN_BIT  = 6;
    localparam logic [1:0]      OSC_MODE_LOWPWR = 2'h0;
    localparam logic [1:0]      OSC_MODE_STDXTAL = 2'h1;
    localparam logic [1:0]      OSC_MODE_HISPD  = 2'h2;
    localparam logic [1:0]      OSC_MODE_RC     = 2'h3;

    // Status register field positions
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_RESET_BIT = 5;
    localparam int STAT_HOLD_BIT  = 6;
    localparam int STAT_BRO_BIT   = 7;
    localparam int STAT_CLR_BIT   = 8;

    typedef enum logic [4:0] {
        RTS_ST_HOLD = 5'h01,
        RTS_ST_BRO  = 5'h02,
        RTS_ST_PUD  = 5'h04,
        RTS_ST_OSU  = 5'h08,
        RTS_ST_RUN  = 5'h10
    } rts_state_t;

endpackage : rts_pkg

//--- core/rts_sequencer.sv
// Purpose: Reset and start-up sequencer: power-on, master clear, brown-out,
//          power-up delay on the RC time base and oscillator start-up count
// Assumes: All inputs synchronous to clk_in except rc_timebase_in and
//          osc_input_clock_in, which are sampled and edge-detected here
// Notes:   Configuration word is writable only while prog_mode_in is high
module rts_sequencer #(
    parameter int unsigned POWERUP_RC_TICKS        = rts_pkg::POWERUP_RC_TICKS,
    parameter int unsigned BROWNOUT_QUALIFY_CYCLES = rts_pkg::BROWNOUT_QUALIFY_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // Detector and pin inputs
    input  wire logic        por_pulse_in,
    input  wire logic        master_clear_n_in,
    input  wire logic        undervoltage_in,
    input  wire logic        watchdog_reset_in,
    input  wire logic        rc_timebase_in,
    input  wire logic        osc_input_clock_in,
    // Core interaction
    input  wire logic        sleep_in,
    input  wire logic        wake_event_in,
    input  wire logic        prog_mode_in,
    output logic             core_reset_out,
    output logic             core_hold_out,
    output logic             watchdog_enable_out,
    // Avalon-MM slave
    input  wire logic [15:0] avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out
);

    localparam logic [rts_pkg::PUD_CNT_W-1:0] PUD_LAST =
        rts_pkg::PUD_CNT_W'(POWERUP_RC_TICKS - 1);
    localparam logic [rts_pkg::OSU_CNT_W-1:0] OSU_LAST =
        rts_pkg::OSU_CNT_W'(rts_pkg::OSU_OSC_CYCLES - 1);
    localparam logic [rts_pkg::BRO_CNT_W-1:0] BRO_LAST =
        rts_pkg::BRO_CNT_W'(BROWNOUT_QUALIFY_CYCLES - 1);
    localparam logic [rts_pkg::CLR_CNT_W-1:0] CLR_LAST =
        rts_pkg::CLR_CNT_W'(rts_pkg::CLR_FILTER_CYCLES - 1);

    typedef struct packed {
        rts_pkg::rts_state_t               state;
        logic [rts_pkg::CFG_W-1:0]         cfg;
        logic                              start_osu;
        logic                              wake;
        logic [rts_pkg::PUD_CNT_W-1:0]     pud_cnt;
        logic [rts_pkg::OSU_CNT_W-1:0]     osu_cnt;
        logic [rts_pkg::BRO_CNT_W-1:0]     bro_cnt;
        logic                              bro_active;
        logic [rts_pkg::CLR_CNT_W-1:0]     clr_cnt;
        logic                              clr_hold;
        logic [2:0]                        rc_sync;
        logic [2:0]                        osc_sync;
        logic                              core_reset;
        logic                              core_hold;
        logic                              wait_req;
        logic [31:0]                       rdata;
    } rts_regs_t;

    rts_regs_t st_r;
    rts_regs_t st_nxt;

    function automatic logic rts_is_crystal(input logic [1:0] mode);
        return (mode == rts_pkg::OSC_MODE_LOWPWR) || (mode == rts_pkg::OSC_MODE_STDXTAL) ||
               (mode == rts_pkg::OSC_MODE_HISPD);
    endfunction : rts_is_crystal

    logic [1:0] osc_mode;
    logic       bro_en;
    logic       pud_en;
    logic       crystal;
    logic       rc_tick;
    logic       osc_tick;
    logic       uv_qual;
    logic       bus_req;
    logic       hit_cfg;
    logic       hit_status;

    assign osc_mode = st_r.cfg[rts_pkg::CFG_OSC_LSB +: 2];
    assign crystal  = rts_is_crystal(osc_mode);
    assign bro_en   = st_r.cfg[rts_pkg::CFG_BRO_EN_BIT];
    assign pud_en   = !st_r.cfg[rts_pkg::CFG_PUD_EN_N] || bro_en;
    // edges from second and third stages only
    assign rc_tick  = st_r.rc_sync[1] && !st_r.rc_sync[2];
    assign osc_tick = st_r.osc_sync[1] && !st_r.osc_sync[2];
    assign uv_qual  = bro_en && undervoltage_in;
    assign bus_req  = avs_read_in || avs_write_in;
    assign hit_cfg    = (avs_address_in[15:2] == rts_pkg::REG_CONFIG_IDX);
    assign hit_status = (avs_address_in[15:2] == rts_pkg::REG_STATUS_IDX);

    always_comb begin
        st_nxt = st_r;

        st_nxt.rc_sync  = {st_r.rc_sync[1:0], rc_timebase_in};
        st_nxt.osc_sync = {st_r.osc_sync[1:0], osc_input_clock_in};

        if (master_clear_n_in) begin
            st_nxt.clr_cnt  = '0;
            st_nxt.clr_hold = 1'b0;
        end else if (st_r.clr_cnt == CLR_LAST) begin
            st_nxt.clr_hold = 1'b1;
        end else begin
            st_nxt.clr_cnt = st_r.clr_cnt + 1'b1;
        end

        if (!uv_qual) begin
            st_nxt.bro_cnt    = '0;
            st_nxt.bro_active = 1'b0;
        end else if (st_r.bro_cnt == BRO_LAST) begin
            st_nxt.bro_active = 1'b1;
        end else begin
            st_nxt.bro_cnt = st_r.bro_cnt + 1'b1;
        end

        if (por_pulse_in) begin
            st_nxt.state     = rts_pkg::RTS_ST_HOLD;
            st_nxt.start_osu = 1'b1;
            st_nxt.wake      = 1'b0;
            st_nxt.pud_cnt   = '0;
            st_nxt.osu_cnt   = '0;
        end else if (st_r.bro_active) begin
            st_nxt.state     = rts_pkg::RTS_ST_BRO;
            st_nxt.start_osu = 1'b0;
            st_nxt.wake      = 1'b0;
            st_nxt.pud_cnt   = '0;
        end else begin
            unique case (st_r.state)
                rts_pkg::RTS_ST_HOLD: begin
                    if (pud_en) begin
                        st_nxt.state = rts_pkg::RTS_ST_PUD;
                    end else if (st_r.start_osu && crystal) begin
                        st_nxt.state = rts_pkg::RTS_ST_OSU;
                    end else begin
                        st_nxt.state = rts_pkg::RTS_ST_RUN;
                    end
                end
                rts_pkg::RTS_ST_BRO: begin
                    if (!undervoltage_in) begin
                        st_nxt.state   = rts_pkg::RTS_ST_PUD;
                        st_nxt.pud_cnt = '0;
                    end
                end
                rts_pkg::RTS_ST_PUD: begin
                    if (uv_qual) begin
                        st_nxt.state   = rts_pkg::RTS_ST_BRO;
                        st_nxt.pud_cnt = '0;
                    end else if (rc_tick) begin
                        if (st_r.pud_cnt == PUD_LAST) begin
                            if (st_r.start_osu && crystal) begin
                                st_nxt.state   = rts_pkg::RTS_ST_OSU;
                                st_nxt.osu_cnt = '0;
                            end else begin
                                st_nxt.state = rts_pkg::RTS_ST_RUN;
                            end
                        end else begin
                            st_nxt.pud_cnt = st_r.pud_cnt + 1'b1;
                        end
                    end
                end
                rts_pkg::RTS_ST_OSU: begin
                    if (osc_tick) begin
                        if (st_r.osu_cnt == OSU_LAST) begin
                            st_nxt.state = rts_pkg::RTS_ST_RUN;
                            st_nxt.wake  = 1'b0;
                        end else begin
                            st_nxt.osu_cnt = st_r.osu_cnt + 1'b1;
                        end
                    end
                end
                rts_pkg::RTS_ST_RUN: begin
                    if (sleep_in && wake_event_in && crystal) begin
                        st_nxt.state   = rts_pkg::RTS_ST_OSU;
                        st_nxt.osu_cnt = '0;
                        st_nxt.wake    = 1'b1;
                    end
                end
                default: begin
                    st_nxt.state = rts_pkg::RTS_ST_HOLD;
                end
            endcase
        end

        st_nxt.core_reset = por_pulse_in || st_r.clr_hold || st_r.bro_active ||
                            watchdog_reset_in ||
                            ((st_r.state != rts_pkg::RTS_ST_RUN) && !st_r.wake);
        st_nxt.core_hold  = (st_r.state != rts_pkg::RTS_ST_RUN);

        // Bus slave: one wait cycle, write commits on the acknowledge edge
        st_nxt.wait_req = !(bus_req && st_r.wait_req);
        if (bus_req && st_r.wait_req) begin
            st_nxt.rdata = '0;
            if (avs_read_in && hit_status) begin
                st_nxt.rdata[rts_pkg::STAT_STATE_LSB +: 5] = st_r.state;
                st_nxt.rdata[rts_pkg::STAT_RESET_BIT]      = st_r.core_reset;
                st_nxt.rdata[rts_pkg::STAT_HOLD_BIT]       = st_r.core_hold;
                st_nxt.rdata[rts_pkg::STAT_BRO_BIT]        = st_r.bro_active;
                st_nxt.rdata[rts_pkg::STAT_CLR_BIT]        = st_r.clr_hold;
            end else if (avs_read_in && hit_cfg && prog_mode_in) begin
                st_nxt.rdata[rts_pkg::CFG_W-1:0] = st_r.cfg;
            end
        end
        if (avs_write_in && !st_r.wait_req && hit_cfg && prog_mode_in) begin
            if (avs_byteenable_in[0]) begin
                st_nxt.cfg[7:0] = avs_writedata_in[7:0];
            end
            if (avs_byteenable_in[1]) begin
                st_nxt.cfg[13:8] = avs_writedata_in[13:8];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_r <= '{
                state:      rts_pkg::RTS_ST_HOLD,
                cfg:        rts_pkg::CFG_RESET,
                start_osu:  1'b1,
                wake:       1'b0,
                pud_cnt:    '0,
                osu_cnt:    '0,
                bro_cnt:    '0,
                bro_active: 1'b0,
                clr_cnt:    '0,
                clr_hold:   1'b0,
                rc_sync:    '0,
                osc_sync:   '0,
                core_reset: 1'b1,
                core_hold:  1'b1,
                wait_req:   1'b1,
                rdata:      '0
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    assign core_reset_out      = st_r.core_reset;
    assign core_hold_out       = st_r.core_hold;
    assign avs_readdata_out    = st_r.rdata;
    assign avs_waitrequest_out = st_r.wait_req;
    // Watchdog enable is a config bit, so it is a flop output
    assign watchdog_enable_out = st_r.cfg[rts_pkg::CFG_WDOG_EN_BIT];

    // Checks

    AST_PUD_HOLDS_RESET: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (st_r.state == rts_pkg::RTS_ST_PUD) |=> core_reset_out)
        else $error("reset not held during power-up delay");

    AST_PUD_RC_ONLY: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (st_r.state == rts_pkg::RTS_ST_PUD && !rc_tick && !uv_qual && !por_pulse_in
         && !st_r.bro_active) |=> $stable(st_r.pud_cnt))
        else $error("power-up counter moved without an RC tick");

    AST_PUD_SKIPPED: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (st_r.state == rts_pkg::RTS_ST_HOLD && !pud_en && !por_pulse_in
         && !st_r.bro_active) |=> (st_r.state != rts_pkg::RTS_ST_PUD))
        else $error("disabled power-up delay was entered");

    AST_OSU_FULL_COUNT: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (st_r.state == rts_pkg::RTS_ST_OSU && st_nxt.state == rts_pkg::RTS_ST_RUN)
        |-> (st_r.osu_cnt == OSU_LAST && osc_tick))
        else $error("start-up count ended early");

    sequence s_enter_osu;
        (st_r.state != rts_pkg::RTS_ST_OSU) ##1 (st_r.state == rts_pkg::RTS_ST_OSU);
    endsequence

    AST_OSU_CRYSTAL_ONLY: assert property (
        @(posedge clk_in) disable iff (rst_in)
        s_enter_osu |-> $past(crystal))
        else $error("start-up count entered outside crystal mode");

    AST_POR_RESTARTS: assert property (
        @(posedge clk_in) disable iff (rst_in)
        por_pulse_in |=> (st_r.state == rts_pkg::RTS_ST_HOLD && st_r.start_osu
                          && core_reset_out))
        else $error("power-on event did not restart sequence");

    AST_POR_DELAY_FIRST: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (st_r.state == rts_pkg::RTS_ST_HOLD && pud_en && !por_pulse_in
         && !st_r.bro_active) |=> (st_r.state == rts_pkg::RTS_ST_PUD))
        else $error("power-up delay not started first");

    AST_RELEASE_AFTER_LAST: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (st_r.state == rts_pkg::RTS_ST_RUN && !st_r.clr_hold && !st_r.bro_active
         && !por_pulse_in && !watchdog_reset_in) |=> !core_reset_out)
        else $error("core held after sequence complete");

    sequence s_clr_release;
        st_r.clr_hold ##1 (!st_r.clr_hold && st_r.state == rts_pkg::RTS_ST_RUN
                           && !st_r.bro_active && !por_pulse_in && !watchdog_reset_in);
    endsequence

    AST_CLR_IMMEDIATE: assert property (
        @(posedge clk_in) disable iff (rst_in)
        s_clr_release |=> !core_reset_out)
        else $error("master-clear release delayed execution");

    AST_BRO_DISABLED: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !bro_en |=> !st_r.bro_active)
        else $error("brown-out active while disabled");

    AST_BRO_QUALIFY: assert property (
        @(posedge clk_in) disable iff (rst_in)
        $rose(st_r.bro_active) |-> ($past(st_r.bro_cnt) == BRO_LAST && $past(uv_qual)))
        else $error("brown-out asserted before qualification time");

    AST_BRO_THEN_PUD: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (st_r.state == rts_pkg::RTS_ST_BRO && !undervoltage_in && !por_pulse_in
         && !st_r.bro_active) |=> (st_r.state == rts_pkg::RTS_ST_PUD && st_r.pud_cnt == '0))
        else $error("power-up delay did not follow brown-out");

    AST_BRO_RESTART: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (st_r.state == rts_pkg::RTS_ST_PUD && uv_qual && !por_pulse_in)
        |=> (st_r.state == rts_pkg::RTS_ST_BRO && st_r.pud_cnt == '0))
        else $error("undervoltage did not clear power-up delay");

    AST_BRO_FORCES_PUD: assert property (
        @(posedge clk_in) disable iff (rst_in)
        bro_en |-> pud_en)
        else $error("power-up delay off while brown-out enabled");

    AST_CLR_FILTER: assert property (
        @(posedge clk_in) disable iff (rst_in)
        $rose(st_r.clr_hold) |-> ($past(st_r.clr_cnt) == CLR_LAST
                                  && $past(!master_clear_n_in)))
        else $error("master-clear glitch was not filtered");

    AST_CFG_PROTECTED: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !prog_mode_in |=> $stable(st_r.cfg))
        else $error("config changed outside programming mode");

    AST_WAKE_OST: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (st_r.state == rts_pkg::RTS_ST_RUN && sleep_in && wake_event_in && crystal
         && !por_pulse_in && !st_r.bro_active)
        |=> (st_r.state == rts_pkg::RTS_ST_OSU) ##1 core_hold_out)
        else $error("wake did not start the start-up count");

    AST_COMBINED_RESET: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (st_r.clr_hold || st_r.bro_active || watchdog_reset_in) |=> core_reset_out)
        else $error("reset source not reflected on core reset");

endmodule : rts_sequencer

//--- test/rts_partner.sv
// Purpose: Far-side sources: RC time base and crystal oscillator input
// Assumes: Both sources run free, locked to clk_in so that runs repeat
// Notes:   Oscillator at clk/4, half the clk/2 rate the input sampler can still edge-detect
module rts_partner (
    // Clock
    input  wire logic clk_in,
    // Sources
    output logic      rc_timebase_out,
    output logic      osc_clock_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] cnt_r = 3'h0;
    always_ff @(posedge clk_in) begin
        cnt_r <= cnt_r + 3'h1;
    end
    assign rc_timebase_out = cnt_r[2];
    assign osc_clock_out   = cnt_r[1];
endmodule : rts_partner

//--- test/tb.sv
// Purpose: Self-checking bench for the reset and start-up sequencer
// Assumes: Short delay and qualify counts; source periods of 8 and 4 cycles
// Notes:   Release times are predicted from the source periods with sync slack
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TICKS = 8;
    localparam int QUAL  = 16;
    logic        clk_in = 1'b0, rst_in = 1'b1, por = 1'b0, mc_n = 1'b1, uv = 1'b0;
    logic        wd = 1'b0, slp = 1'b0, wake = 1'b0, prog = 1'b0, rd = 1'b0, wr = 1'b0;
    logic        rc, osc, crst, chold, wd_en, wreq, hit;
    logic [15:0] addr = 16'h0000;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic [3:0]  be = 4'hF;
    int          bad_count = 0, n_compared = 0, n, e, g;
    always #5 clk_in = ~clk_in;
    rts_partner far (.clk_in(clk_in), .rc_timebase_out(rc), .osc_clock_out(osc));
    rts_sequencer #(.POWERUP_RC_TICKS(TICKS), .BROWNOUT_QUALIFY_CYCLES(QUAL)) dut (
        .clk_in(clk_in), .rst_in(rst_in), .por_pulse_in(por), .master_clear_n_in(mc_n),
        .undervoltage_in(uv), .watchdog_reset_in(wd), .rc_timebase_in(rc),
        .osc_input_clock_in(osc), .sleep_in(slp), .wake_event_in(wake), .prog_mode_in(prog),
        .core_reset_out(crst), .core_hold_out(chold), .watchdog_enable_out(wd_en),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq));
    // Holds the request until waitrequest is sampled low, then releases
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_in);
        rd <= ~w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do begin @(posedge clk_in); k++; end while (wreq !== 1'b0 && k < 50);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic cfg(input logic [1:0] m, input logic pn, input logic bo);
        bus(1'b1, 16'h801C, {18'h0, 7'h7F, bo, 2'h3, pn, 1'b1, m});
    endtask : cfg
    task automatic settle();
        n = 0;
        do begin @(posedge clk_in); n++; end while (crst !== 1'b0 && n < 20000);
    endtask : settle
    // Source 0 is the active-low clear pin, 1 watchdog, 2 undervoltage, 3 wake
    task drive(input int w, input logic on);
        case (w)
            0: mc_n <= ~on;
            1: wd <= on;
            2: uv <= on;
            default: wake <= on;
        endcase
    endtask : drive
    task automatic low(input int c, input int w);
        hit = 1'b0;
        drive(w, 1'b1);
        repeat (c) begin @(posedge clk_in); hit |= crst; end
        drive(w, 1'b0);
    endtask : low
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (60000) @(posedge clk_in);
        bad_count++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h0F19));
        repeat (16) @(posedge clk_in);
        `CHK("core_reset_in_reset", 1'b1, crst)
        rst_in <= 1'b0;
        settle();
        `CHK("core_reset_default", 1'b1, n >= TICKS * 8 - 8 && n <= TICKS * 8 + 24)
        bus(1'b0, 16'h0004, 32'h0);
        `CHK("status_run", 9'h010, q[8:0])
        bus(1'b0, 16'h801C, 32'h0);
        `CHK("cfg_locked_read", 32'h0, q)
        bus(1'b1, 16'h801C, 32'h0);
        prog <= 1'b1;
        bus(1'b0, 16'h801C, 32'h0);
        `CHK("cfg_unprogrammed", 32'h3FFF, q)
        bus(1'b0, 16'h0100, 32'h0);
        `CHK("unmapped_read", 32'h0, q)
        for (int m = 0; m < 4; m++) begin
            g = $urandom % 2;
            cfg(m[1:0], g[0], 1'b0);
            por <= 1'b1;
            @(posedge clk_in);
            por <= 1'b0;
            settle();
            e = (g == 0 ? TICKS * 8 : 0) + (m != 3 ? 1024 * 4 : 0);
            `CHK("por_release", 1'b1, n >= e - 8 && n <= e + 24)
        end
        cfg(2'h3, 1'b1, 1'b0);
        // Glitch shorter than the 20-cycle filter
        low(1 + $urandom % 17, 0);
        `CHK("clear_glitch", 1'b0, hit)
        low(40, 0);
        `CHK("clear_held", 1'b1, crst)
        settle();
        `CHK("clear_release", 1'b1, n <= 3)
        low(1, 1);
        @(posedge clk_in);
        `CHK("watchdog_reset", 1'b1, crst)
        settle();
        low(40, 2);
        `CHK("uv_ignored", 1'b0, hit)
        cfg(2'h3, 1'b1, 1'b1);
        low(QUAL - 6, 2);
        `CHK("uv_short", 1'b0, hit)
        low(QUAL + 10, 2);
        `CHK("uv_long", 1'b1, crst)
        settle();
        `CHK("uv_delay", 1'b1, n >= TICKS * 8 - 8 && n <= TICKS * 8 + 24)
        low(QUAL + 10, 2);
        repeat (30) @(posedge clk_in);
        low(3, 2);
        settle();
        `CHK("uv_restart", 1'b1, n >= TICKS * 8 - 8 && n <= TICKS * 8 + 24)
        cfg(2'h1, 1'b1, 1'b0);
        slp <= 1'b1;
        low(1, 3);
        slp <= 1'b0;
        repeat (3) @(posedge clk_in);
        `CHK("wake_hold", 2'h2, {chold, crst})
        repeat (4200) @(posedge clk_in);
        `CHK("wake_done", 1'b0, chold)
        stop_test();
    end
endmodule : tb
